//--- bench/ptmr_bench.sv
// Self-checking bench for the periodic timer register block.
// Assumes ptmr_top answers APB in the access cycle and syncs its pins.
`timescale 1ns/100ps
module ptmr_bench;
	import ptmr_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic i_mclk = 1'b0;
	logic i_rst_n = 1'b0;
	ptmr_apb_req_s i_apb = '0;
	ptmr_apb_rsp_s o_apb;
	logic i_high_clk = 1'b0;
	logic i_tbc_clk = 1'b0;
	logic i_ext_count_pin = 1'b0;
	logic i_timer_pin_in = 1'b0;
	logic o_timer_output_pin;
	logic [9:0] o_capture_value;
	ptmr_evt_s o_evt;
	int bad_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	int caps = 0;
	int pmat = 0;
	int p0;
	logic [31:0] rd;
	logic err;
	logic [9:0] v, got, mx, a;
	logic [1:0] io;
	logic oc, pol, ex;
	ptmr_top uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_apb(i_apb), .o_apb(o_apb),
		.i_high_clk(i_high_clk), .i_tbc_clk(i_tbc_clk), .i_ext_count_pin(i_ext_count_pin),
		.i_timer_pin_in(i_timer_pin_in), .o_timer_output_pin(o_timer_output_pin),
		.o_capture_value(o_capture_value), .o_evt(o_evt));
	// The clock toggles every 20 ns, half of its 40 ns period.
	always #20 i_mclk = ~i_mclk;
	// Side clocks wander at random; captures are counted; a hang ends the run.
	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		i_high_clk <= 1'($urandom);
		i_tbc_clk <= 1'($urandom);
		if (o_evt.cap_evt === 1'b1) caps <= caps + 1;
		if (o_evt.match_p === 1'b1) pmat <= pmat + 1;
		if (cycles == 40000) begin
			bad_count = bad_count + 1;
			end_sim();
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	// Counts a comparison and reports a mismatch at once.
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	// One APB transfer; an idle edge follows so requests never collide in a time step.
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [7:0] d);
		int n;
		n = 0;
		i_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: ad, pwdata: {24'h00_0000, d}};
		@(posedge i_mclk);
		i_apb.penable <= 1'b1;
		do begin
			@(posedge i_mclk);
			n++;
		end while (o_apb.pready !== 1'b1 && n < 20);
		chk("pready", o_apb.pready, 1'b1);
		rd = o_apb.prdata;
		err = o_apb.pslverr;
		i_apb.psel <= 1'b0;
		i_apb.penable <= 1'b0;
		@(posedge i_mclk);
	endtask : apb
	// Low byte goes to the buffer first; the high byte commits both.
	task automatic wr10(input logic [7:0] hi, input logic [9:0] val);
		apb(1'b1, hi - 8'h04, val[7:0]);
		apb(1'b1, hi, {6'h3F, val[9:8]});
	endtask : wr10
	// High byte read latches the low byte, which is read next.
	task automatic rd10(input logic [7:0] hi, output logic [9:0] val);
		apb(1'b0, hi, 8'h00);
		chk("hi_unused", rd & 32'hFFFF_FFFC, 32'h0000_0000);
		val[9:8] = rd[1:0];
		apb(1'b0, hi - 8'h04, 8'h00);
		val[7:0] = rd[7:0];
	endtask : rd10
	// Switches off, sets mode and restarts with a rising on bit.
	task automatic setup(input logic [7:0] c1, input logic [7:0] c0);
		apb(1'b1, OFS_CTRL0, 8'h10);
		apb(1'b1, OFS_CTRL1, c1);
		apb(1'b1, OFS_CTRL0, c0);
	endtask : setup
	// One clean pulse on the chosen pin.
	task automatic pulse(input logic ext);
		if (ext) i_ext_count_pin <= 1'b1;
		else i_timer_pin_in <= 1'b1;
		repeat (6) @(posedge i_mclk);
		if (ext) i_ext_count_pin <= 1'b0;
		else i_timer_pin_in <= 1'b0;
		repeat (8) @(posedge i_mclk);
	endtask : pulse
	// Prints the counts and the verdict, then stops.
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		void'($urandom(9));
		repeat (2) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		@(posedge i_mclk);
		// every register reads zero after reset.
		for (int k = 0; k < 8; k++) begin
			apb(1'b0, 8'(k * 4), 8'h00);
			chk("reset", rd, 32'h0000_0000);
		end
		// control readback; unused control bits read zero.
		repeat (8) begin
			v = 10'($urandom);
			apb(1'b1, OFS_CTRL1, v[7:0]);
			apb(1'b0, OFS_CTRL1, 8'h00);
			chk("ctrl1", rd, {24'h00_0000, v[7:0]});
			apb(1'b1, OFS_CTRL0, v[7:0] & 8'hF7);
			apb(1'b0, OFS_CTRL0, 8'h00);
			chk("ctrl0", rd, {24'h00_0000, v[7:0] & 8'hF0});
			wr10(OFS_CMPA_HI, v);
			wr10(OFS_CMPP_HI, ~v);
			rd10(OFS_CMPA_HI, got);
			chk("cmp_a", got, v);
			rd10(OFS_CMPP_HI, got);
			chk("cmp_p", got, 10'(~v));
		end
		apb(1'b1, 8'h20, 8'hFF);
		chk("slverr", err, 1'b1);
		apb(1'b0, 8'h20, 8'h00);
		chk("unmapped", rd, 32'h0000_0000);
		$display("test registers done");
		// run, pause, stop and restart in timer mode.
		wr10(OFS_CMPP_HI, 10'h000);
		setup(8'hC4, 8'h18);
		repeat (300) @(posedge i_mclk);
		rd10(OFS_CNT_HI, a);
		chk("running", a > 10'h0FA, 1'b1);
		chk("tmr_pin", o_timer_output_pin, 1'b0);
		apb(1'b1, OFS_CTRL0, 8'h98);
		rd10(OFS_CNT_HI, a);
		repeat (50) @(posedge i_mclk);
		rd10(OFS_CNT_HI, got);
		chk("paused", got, a);
		apb(1'b1, OFS_CTRL0, 8'h18);
		repeat (20) @(posedge i_mclk);
		rd10(OFS_CNT_HI, got);
		chk("resumed", got > a, 1'b1);
		apb(1'b1, OFS_CTRL0, 8'h10);
		rd10(OFS_CNT_HI, a);
		repeat (30) @(posedge i_mclk);
		rd10(OFS_CNT_HI, got);
		chk("off_hold", got, a);
		apb(1'b1, OFS_CTRL0, 8'h18);
		rd10(OFS_CNT_HI, got);
		chk("on_clear", got < 10'h00A, 1'b1);
		$display("test counting done");
		// clear source by mode and clear-select.
		for (int c = 0; c < 3; c++) begin
			wr10(OFS_CMPA_HI, 10'h01E);
			wr10(OFS_CMPP_HI, 10'h03C);
			setup(c == 2 ? 8'hA1 : (c == 1 ? 8'hC1 : 8'hC0), 8'h18);
			p0 = pmat;
			mx = 10'h000;
			repeat (16) begin
				repeat (1 + $urandom % 40) @(posedge i_mclk);
				rd10(OFS_CNT_HI, got);
				if (got > mx) mx = got;
			end
			chk("cnt_max", mx <= (c == 1 ? 10'h01E : 10'h03C), 1'b1);
			chk("past_a", mx > 10'h01E, c != 1);
			chk("match_p", pmat != p0, c != 1);
		end
		$display("test clearing done");
		// every clock source; external edges counted exactly.
		wr10(OFS_CMPP_HI, 10'h000);
		for (int s = 0; s < 8; s++) begin
			setup(8'hC0, 8'(s * 16 + 8));
			if (s < 6) begin
				// The divide-by-64 source needs a longer wait to see a tick for sure.
				repeat (s == 3 ? 4000 : 800) @(posedge i_mclk);
				rd10(OFS_CNT_HI, got);
				chk("int_clk", got != 10'h000, 1'b1);
				if (s == 1) chk("sys_clk", got > 10'h2BC, 1'b1);
				if (s == 0) chk("sys4_clk", got > 10'h0BE && got < 10'h0DC, 1'b1);
			end else begin
				v = 10'(3 + $urandom % 6);
				repeat (v) pulse(1'b1);
				rd10(OFS_CNT_HI, got);
				chk("ext_clk", got, v);
				apb(1'b1, OFS_CTRL0, 8'(s * 16 + 8'h88));
				repeat (3) pulse(1'b1);
				rd10(OFS_CNT_HI, got);
				chk("ext_pause", got, v);
			end
		end
		$display("test clocks done");
		// compare output for all levels and functions.
		for (int k = 0; k < 16; k++) begin
			{pol, oc, io} = 4'(k);
			a = 10'(20 + $urandom % 20);
			wr10(OFS_CMPA_HI, a);
			setup({2'b00, io, oc, pol, 2'b01}, 8'h18);
			repeat (2) @(posedge i_mclk);
			chk("init_lvl", o_timer_output_pin, oc ^ pol);
			v = 10'h000;
			do begin
				@(posedge i_mclk);
				v++;
			end while (o_evt.match_a !== 1'b1 && v < 10'h064);
			chk("match_time", v, a);
			repeat (3) @(posedge i_mclk);
			ex = io == 2'b00 ? oc : (io == 2'b01 ? 1'b0 : (io == 2'b10 ? 1'b1 : ~oc));
			chk("match_lvl", o_timer_output_pin, ex ^ pol);
		end
		$display("test compare done");
		// capture edge choice and trigger source.
		for (int k = 0; k < 8; k++) begin
			{ex, io} = 3'(k);
			setup({2'b01, io, 2'b00, ex, 1'b0}, 8'h18);
			repeat (5 + $urandom % 30) @(posedge i_mclk);
			apb(1'b1, OFS_CTRL0, 8'h98);
			rd10(OFS_CNT_HI, mx);
			a = 10'(caps);
			pulse(ex);
			chk("cap_edges", caps - a, io == 2'b10 ? 2 : (io == 2'b11 ? 0 : 1));
			if (io != 2'b11) chk("cap_value", o_capture_value, mx);
			a = 10'(caps);
			pulse(~ex);
			chk("cap_source", caps - a, 0);
		end
		$display("test capture done");
		end_sim();
	end
endmodule : ptmr_bench

//--- design/ptmr_pkg.sv
// Package for the periodic timer register block.
// Assumes an APB slave with 32-bit data, one byte register per aligned word.
package ptmr_pkg;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL0 = 8'h00;
	localparam logic [7:0] OFS_CTRL1 = 8'h04;
	localparam logic [7:0] OFS_CNT_LO = 8'h08;
	localparam logic [7:0] OFS_CNT_HI = 8'h0C;
	localparam logic [7:0] OFS_CMPA_LO = 8'h10;
	localparam logic [7:0] OFS_CMPA_HI = 8'h14;
	localparam logic [7:0] OFS_CMPP_LO = 8'h18;
	localparam logic [7:0] OFS_CMPP_HI = 8'h1C;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [9:0] RST_VAL10 = 10'h000;
	localparam logic [9:0] CNT_MAX = 10'h3FF;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int POS_PAUSE = 7;
	localparam int POS_CKSEL = 4;
	localparam int POS_ON = 3;
	localparam int POS_MODE = 6;
	localparam int POS_IOSEL = 4;
	localparam int POS_OC = 3;
	localparam int POS_POL = 2;
	localparam int POS_CAPTS = 1;
	localparam int POS_CCLR = 0;
	// ----------------------------------------
	// Prescaler counts
	// ----------------------------------------
	localparam logic [5:0] DIV_SYS4 = 6'h03;
	localparam logic [5:0] DIV_H16 = 6'h0F;
	localparam logic [5:0] DIV_H64 = 6'h3F;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		PTMR_CMP = 2'h0, PTMR_CAP = 2'h1, PTMR_PWM = 2'h2, PTMR_TMR = 2'h3
	} ptmr_mode_e;
	typedef enum logic [2:0] {
		CK_SYS4 = 3'h0, CK_SYS = 3'h1, CK_H16 = 3'h2, CK_H64 = 3'h3,
		CK_TBC = 3'h4, CK_H = 3'h5, CK_EXTR = 3'h6, CK_EXTF = 3'h7
	} ptmr_cksel_e;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001, ST_SETUP = 3'b010, ST_ACCESS = 3'b100
	} ptmr_apb_e;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} ptmr_apb_req_s;
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ptmr_apb_rsp_s;
	typedef struct packed {
		logic cap_evt;
		logic match_a;
		logic match_p;
	} ptmr_evt_s;
endpackage : ptmr_pkg

//--- design/ptmr_top.sv
// Periodic 10-bit timer: control registers, counter, compare and output logic.
// Assumes one clock i_mclk; external pins, high clock and time-base clock arrive asynchronously.
`timescale 1ns/100ps
// Behaviour
// - Pause bit holds the counter; clearing it resumes from the held value.
// - Three-bit clock select picks prescaled internal clocks or external pin edges.
// - On bit rising clears counter; falling keeps counter value.
// - On bit low stops counting; high lets counter run.
// - In compare mode, on bit rising restores output to initial level.
// - Two-bit mode field selects compare, capture, PWM/pulse or timer mode.
// - Compare mode, A match: none, low, high or toggle output.
// - PWM mode: force inactive, force active, PWM or single pulse.
// - Capture mode: rising, falling, both edges or disabled capture.
// - Compare mode: no output change when requested level equals initial.
// - Output control bit sets initial level or PWM active level.
// - Polarity bit inverts output pin; no effect in timer mode.
// - Capture source: timer input pin when 0, external count pin when 1.
// - Clear-select 1 clears on A match; 0 on P match or overflow.
// - Overflow clears the counter only when compare P is zero.
// - Clear-select ignored in PWM, single pulse and capture modes; in capture mode it still masks the P match event.
// - Counter readable as low byte plus two-bit high byte.
// - Compare A and P are 10-bit read/write byte pairs.
// - Unimplemented bits read as zero.
// - Low bytes pass through shared buffer, moved on high-byte access.
module ptmr_top (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire ptmr_pkg::ptmr_apb_req_s i_apb,
	output ptmr_pkg::ptmr_apb_rsp_s o_apb,
	input wire logic i_high_clk,
	input wire logic i_tbc_clk,
	input wire logic i_ext_count_pin,
	input wire logic i_timer_pin_in,
	output logic o_timer_output_pin,
	output logic [9:0] o_capture_value,
	output ptmr_pkg::ptmr_evt_s o_evt
);
	import ptmr_pkg::*;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] ctrl0_r;
	logic [7:0] ctrl1_r;
	logic [9:0] cnt_r;
	logic [9:0] cmpa_r;
	logic [9:0] cmpp_r;
	logic [7:0] lbuf_r;
	logic on_d_r;
	logic out_r;
	logic pulse_done_r;
	logic [5:0] div_sys_r;
	logic [5:0] div_h_r;
	ptmr_apb_e apb_st_r;
	ptmr_apb_rsp_s rsp_r;
	ptmr_evt_s evt_r;
	logic [9:0] cap_r;
	logic pin_r;

	wire logic pause = ctrl0_r[POS_PAUSE];
	wire logic on = ctrl0_r[POS_ON];
	wire ptmr_cksel_e cksel = ptmr_cksel_e'(ctrl0_r[POS_CKSEL +: 3]);
	wire ptmr_mode_e mode = ptmr_mode_e'(ctrl1_r[POS_MODE +: 2]);
	wire logic [1:0] iosel = ctrl1_r[POS_IOSEL +: 2];
	wire logic oc = ctrl1_r[POS_OC];
	wire logic pol = ctrl1_r[POS_POL];
	wire logic capts = ctrl1_r[POS_CAPTS];
	wire logic cclr = ctrl1_r[POS_CCLR];

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Three stages per asynchronous input; stage 0 feeds only stage 1.
	logic [2:0] sy_h_r, sy_t_r, sy_e_r, sy_p_r;
	logic h_st_r, t_st_r, e_st_r, p_st_r;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sy_h_r <= 3'h0;
			sy_t_r <= 3'h0;
			sy_e_r <= 3'h0;
			sy_p_r <= 3'h0;
		end else begin
			sy_h_r <= {sy_h_r[1:0], i_high_clk};
			sy_t_r <= {sy_t_r[1:0], i_tbc_clk};
			sy_e_r <= {sy_e_r[1:0], i_ext_count_pin};
			sy_p_r <= {sy_p_r[1:0], i_timer_pin_in};
		end
	end

	// A level counts once the second and third stages agree.
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			h_st_r <= 1'b0;
			t_st_r <= 1'b0;
			e_st_r <= 1'b0;
			p_st_r <= 1'b0;
		end else begin
			if (sy_h_r[1] == sy_h_r[2]) h_st_r <= sy_h_r[2];
			if (sy_t_r[1] == sy_t_r[2]) t_st_r <= sy_t_r[2];
			if (sy_e_r[1] == sy_e_r[2]) e_st_r <= sy_e_r[2];
			if (sy_p_r[1] == sy_p_r[2]) p_st_r <= sy_p_r[2];
		end
	end
	wire logic h_rise = (sy_h_r[1] == sy_h_r[2]) && sy_h_r[2] && !h_st_r;
	wire logic t_rise = (sy_t_r[1] == sy_t_r[2]) && sy_t_r[2] && !t_st_r;
	wire logic e_rise = (sy_e_r[1] == sy_e_r[2]) && sy_e_r[2] && !e_st_r;
	wire logic e_fall = (sy_e_r[1] == sy_e_r[2]) && !sy_e_r[2] && e_st_r;
	wire logic p_rise = (sy_p_r[1] == sy_p_r[2]) && sy_p_r[2] && !p_st_r;
	wire logic p_fall = (sy_p_r[1] == sy_p_r[2]) && !sy_p_r[2] && p_st_r;

	// ----------------------------------------
	// Prescalers and clock select
	// ----------------------------------------
	// Prescalers free-run; the divided tick is a one-cycle enable, not a clock.
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_sys_r <= 6'h00;
			div_h_r <= 6'h00;
		end else begin
			div_sys_r <= (div_sys_r == DIV_SYS4) ? 6'h00 : div_sys_r + 6'h01;
			if (h_rise) div_h_r <= div_h_r + 6'h01;
		end
	end

	logic tick;
	always_comb begin
		case (cksel)
			CK_SYS4: tick = (div_sys_r == DIV_SYS4);
			CK_SYS: tick = 1'b1;
			CK_H16: tick = h_rise && ((div_h_r & DIV_H16) == DIV_H16);
			CK_H64: tick = h_rise && (div_h_r == DIV_H64);
			CK_TBC: tick = t_rise;
			CK_H: tick = h_rise;
			CK_EXTR: tick = e_rise;
			CK_EXTF: tick = e_fall;
			default: tick = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	wire logic on_rise = on && !on_d_r;
	wire logic run = on && !pause;
	wire logic hit_a = run && tick && (cnt_r == cmpa_r);
	wire logic hit_p = run && tick && (cnt_r == cmpp_r) && (cmpp_r != RST_VAL10);
	wire logic ovf = run && tick && (cnt_r == CNT_MAX);
	logic clr;
	// clear source; clear-select unused outside compare and timer modes.
	always_comb begin
		if (mode == PTMR_CMP || mode == PTMR_TMR)
			clr = cclr ? hit_a : (hit_p || (ovf && cmpp_r == RST_VAL10));
		else if (mode == PTMR_PWM)
			clr = hit_p || (ovf && cmpp_r == RST_VAL10);
		else
			clr = ovf && cmpp_r == RST_VAL10;
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r <= RST_VAL10;
			on_d_r <= 1'b0;
		end else begin
			on_d_r <= on;
			if (on_rise) cnt_r <= RST_VAL10;
			else if (clr) cnt_r <= RST_VAL10;
			else if (run && tick) cnt_r <= cnt_r + 10'h001;
		end
	end

	// ----------------------------------------
	// Output pin
	// ----------------------------------------
	// output stage; holds naturally when target equals level.
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			out_r <= 1'b0;
			pulse_done_r <= 1'b0;
		end else begin
			if (on_rise) pulse_done_r <= 1'b0;
			case (mode)
				PTMR_CMP: begin
					if (on_rise) out_r <= oc;
					else if (hit_a && iosel == 2'h1) out_r <= 1'b0;
					else if (hit_a && iosel == 2'h2) out_r <= 1'b1;
					else if (hit_a && iosel == 2'h3) out_r <= !out_r;
				end
				PTMR_PWM: begin
					case (iosel)
						2'h0: out_r <= !oc;
						2'h1: out_r <= oc;
						2'h2: out_r <= (on && cnt_r < cmpa_r) ? oc : !oc;
						default: begin
							out_r <= (on && !pulse_done_r) ? oc : !oc;
							if (hit_a) pulse_done_r <= 1'b1;
						end
					endcase
				end
				default: out_r <= out_r;
			endcase
		end
	end

	// polarity, not applied in timer mode.
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) pin_r <= 1'b0;
		else if (mode == PTMR_TMR) pin_r <= 1'b0;
		else pin_r <= out_r ^ pol;
	end

	// ----------------------------------------
	// Capture
	// ----------------------------------------
	wire logic src_rise = capts ? e_rise : p_rise;
	wire logic src_fall = capts ? e_fall : p_fall;
	logic cap_hit;
	always_comb begin
		case (iosel)
			2'h0: cap_hit = src_rise;
			2'h1: cap_hit = src_fall;
			2'h2: cap_hit = src_rise || src_fall;
			default: cap_hit = 1'b0;
		endcase
	end
	wire logic cap_evt = (mode == PTMR_CAP) && on && cap_hit;

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cap_r <= RST_VAL10;
			evt_r <= '0;
		end else begin
			if (cap_evt) cap_r <= cnt_r;
			evt_r <= '{cap_evt: cap_evt, match_a: hit_a, match_p: hit_p && !(mode != PTMR_PWM && cclr)};
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	wire logic acc = i_apb.psel && i_apb.penable && (apb_st_r == ST_ACCESS);
	wire logic wr = acc && i_apb.pwrite;
	// A read snaps the buffer as its answer is registered, so both bytes come from one count.
	wire logic rd_snap = i_apb.psel && !i_apb.pwrite && (apb_st_r == ST_SETUP);
	wire logic [7:0] wd = i_apb.pwdata[7:0];

	// Three-state slave: every access completes with one wait state.
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) apb_st_r <= ST_IDLE;
		else begin
			case (apb_st_r)
				ST_IDLE: apb_st_r <= (i_apb.psel && !i_apb.penable) ? ST_SETUP : ST_IDLE;
				ST_SETUP: apb_st_r <= ST_ACCESS;
				ST_ACCESS: apb_st_r <= ST_IDLE;
				default: apb_st_r <= ST_IDLE;
			endcase
		end
	end

	// register writes; low bytes land in the shared buffer only.
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl0_r <= RST_CTRL;
			ctrl1_r <= RST_CTRL;
			cmpa_r <= RST_VAL10;
			cmpp_r <= RST_VAL10;
			lbuf_r <= 8'h00;
		end else if (wr) begin
			case (i_apb.paddr)
				OFS_CTRL0: ctrl0_r <= {wd[7:3], 3'h0};
				OFS_CTRL1: ctrl1_r <= wd;
				OFS_CMPA_LO, OFS_CMPP_LO: lbuf_r <= wd;
				OFS_CMPA_HI: cmpa_r <= {wd[1:0], lbuf_r};
				OFS_CMPP_HI: cmpp_r <= {wd[1:0], lbuf_r};
				default: lbuf_r <= lbuf_r;
			endcase
		end else if (rd_snap) begin
			// high-byte read latches the low byte.
			case (i_apb.paddr)
				OFS_CNT_HI: lbuf_r <= cnt_r[7:0];
				OFS_CMPA_HI: lbuf_r <= cmpa_r[7:0];
				OFS_CMPP_HI: lbuf_r <= cmpp_r[7:0];
				default: lbuf_r <= lbuf_r;
			endcase
		end
	end

	logic [7:0] rdat;
	// read mux; upper bits and unused fields read zero.
	always_comb begin
		case (i_apb.paddr)
			OFS_CTRL0: rdat = ctrl0_r;
			OFS_CTRL1: rdat = ctrl1_r;
			OFS_CNT_LO, OFS_CMPA_LO, OFS_CMPP_LO: rdat = lbuf_r;
			OFS_CNT_HI: rdat = {6'h00, cnt_r[9:8]};
			OFS_CMPA_HI: rdat = {6'h00, cmpa_r[9:8]};
			OFS_CMPP_HI: rdat = {6'h00, cmpp_r[9:8]};
			default: rdat = 8'h00;
		endcase
	end
	wire logic mapped = (i_apb.paddr[1:0] == 2'h0) && (i_apb.paddr <= OFS_CMPP_HI);

	// Response registered; pready pulses in the access cycle after setup.
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) rsp_r <= '0;
		else if (apb_st_r == ST_SETUP) rsp_r <= '{pready: 1'b1, pslverr: !mapped, prdata: {24'h00_0000, rdat}};
		else rsp_r <= '0;
	end

	assign o_apb = rsp_r;
	assign o_timer_output_pin = pin_r;
	assign o_capture_value = cap_r;
	assign o_evt = evt_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_on_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		on_rise |=> cnt_r == RST_VAL10) else $error("counter not cleared on enable");
	chk_pause_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(pause && on_d_r && on) |=> $stable(cnt_r) || $past(on_rise)) else $error("counter moved while paused");
	chk_off_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(!on && !$rose(on)) |=> $stable(cnt_r)) else $error("counter moved while off");
	chk_init_level: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(on_rise && mode == PTMR_CMP) |=> out_r == $past(oc)) else $error("initial level not restored");
	chk_cmp_high: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(mode == PTMR_CMP && hit_a && !on_rise && iosel == 2'h2) |=> out_r) else $error("A match did not drive high");
	chk_ovf_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(cmpp_r != RST_VAL10 && !hit_a && !hit_p) |-> !clr) else $error("counter cleared without a match");
	chk_pol_pin: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		mode != PTMR_TMR |=> pin_r == ($past(out_r) ^ $past(pol))) else $error("pin polarity wrong");
	chk_cap_take: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		cap_evt |=> cap_r == $past(cnt_r) && evt_r.cap_evt) else $error("capture not taken");
	chk_rd_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(apb_st_r == ST_SETUP && i_apb.paddr == OFS_CNT_HI) |=> rsp_r.prdata[31:2] == 30'h0) else $error("reserved bits");
endmodule : ptmr_top
